// ==== core/pmc_pkg.sv ====
// Purpose: Shared constants for the PWM output mode control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Printed offsets are not all multiples of four, so they are register indexes
package pmc_pkg;
	// Register indexes as printed; byte address is four times the index
	localparam logic [7:0]  IDX_DUTY2_HIGH  = 8'hd5;
	localparam logic [7:0]  IDX_MODE_CTRL3  = 8'hd7;
	localparam logic [7:0]  IDX_PERIOD_LOW  = 8'hd9;
	localparam logic [7:0]  IDX_PERIOD_HIGH = 8'hd1;
	localparam logic [7:0]  IDX_DUTY2_LOW   = 8'he0;
	localparam logic [7:0]  IDX_IRQ_STATUS  = 8'he1;
	localparam logic [7:0]  IDX_IRQ_MASK    = 8'he2;
	localparam logic [7:0]  IDX_PIN_STATUS  = 8'he3;
	localparam logic [7:0]  IDX_DUTY0       = 8'he4;
	localparam logic [7:0]  IDX_DUTY4       = 8'he5;
	localparam logic [7:0]  IDX_DUTY6       = 8'he6;
	localparam int          ADDR_W          = 12;
	// Control register field positions
	localparam int          BIT_EVEN_HIZ    = 7;
	localparam int          BIT_ODD_HIZ     = 6;
	localparam int          BIT_GROUP       = 5;
	localparam int          BIT_ALIGN       = 4;
	localparam int          BIT_CH6_SRC     = 1;
	localparam int          BIT_FLAG_SEL    = 0;
	// Writable masks: reserved positions are dropped
	localparam logic [7:0]  MASK_CTRL3      = 8'hf3;
	localparam logic [7:0]  MASK_DUTY_HIGH  = 8'h03;
	localparam logic [7:0]  MASK_PER_HIGH   = 8'h0f;
	localparam logic [3:0]  MASK_EVENTS     = 4'h3;
	// Status bit positions
	localparam int          EV_UNDERFLOW    = 0;
	localparam int          EV_OVERFLOW     = 1;
	// Widths and reset values
	localparam int          CNT_W           = 12;
	localparam int          DUTY_W          = 10;
	localparam logic [11:0] CNT_ZERO        = 12'h000;
	localparam logic [11:0] CNT_ONE         = 12'h001;
	localparam logic [9:0]  DUTY_ZERO       = 10'h000;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	typedef enum logic [0:0] {
		PMC_UP   = 1'b0,
		PMC_DOWN = 1'b1
	} pmc_dir_t;
endpackage

// ==== core/pmc_duty_store.sv ====
// Purpose: Small register memory for the channel duty words
// Assumes: One write port, one read port, read data registered
// Notes:   Four words: channels zero, four and six use words zero, two and three
module pmc_duty_store (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_sel,
	input  wire logic [9:0]  wr_data,
	input  wire logic [1:0]  rd_sel,
	output logic      [9:0]  rd_data,
	output logic      [39:0] all_words
);
	typedef struct packed {
		logic [3:0][9:0] word; // Duty words
		logic [9:0]      rd;   // Registered read data
	} pmc_store_t;
	pmc_store_t st;
	pmc_store_t next_st;

	// Write and registered read
	always_comb begin
		next_st = st;
		if (wr_en) begin
			next_st.word[wr_sel] = wr_data;
		end
		next_st.rd = st.word[rd_sel];
		if (!aresetn) begin
			next_st = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	assign rd_data   = st.rd;
	assign all_words = st.word;
endmodule

// ==== core/pmc_top.sv ====
// Purpose: PWM output mode control with a shared 12-bit period counter
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   Pin output enables are high while a pin is driven
// Functional notes
// - Even Hi-Z bit tristates all even pins
// - Even Hi-Z bit loads from config at reset
// - Odd Hi-Z bit tristates all odd pins
// - Odd Hi-Z bit loads from config at reset
// - Group bit makes channels 0,2,4 follow 0
// - Alignment bit picks edge or centre counting
// - Channel-6 pin source: own or channel-2 duty
// - Flag on underflow or overflow per select
// - Flag select only matters centre-aligned
// - Channel-2 duty is ten bits, reserved bits
// - Period counter is twelve bits
module pmc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cfg_even_hiz,
	input  wire logic        cfg_odd_hiz,
	input  wire logic [3:0]  port_output_mode_regs,
	input  wire logic        channel6_pin_enable,
	output logic      [7:0]  pwm_out,
	output logic      [7:0]  pwm_oe,
	output logic             pwm_event_flag,
	output logic             irq
);
	// Whole block state in one struct
	typedef struct packed {
		logic        awready;       // Address taken
		logic        wready;        // Data taken
		logic        got_aw;        // Address held
		logic        got_w;         // Data held
		logic [11:0] waddr;         // Held write address
		logic [31:0] wdata;         // Held write data
		logic [3:0]  wstrb;         // Held strobes
		logic        bvalid;        // Write answer pending
		logic [1:0]  bresp;         // Write answer code
		logic        arready;       // Read address taken
		logic        rvalid;        // Read answer pending
		logic [31:0] rdata;         // Read answer data
		logic [1:0]  rresp;         // Read answer code
		logic        rd_store;      // Read waits on duty store
		logic [7:0]  ctrl3;         // Mode control register
		logic [7:0]  duty2_low;     // Channel-2 duty low byte
		logic [7:0]  duty2_high;    // Channel-2 duty high bits
		logic [7:0]  per_low;       // Period low byte
		logic [7:0]  per_high;      // Period high nibble
		logic [11:0] cnt;           // Shared period counter
		pmc_pkg::pmc_dir_t dir;     // Counting direction
		logic [3:0]  status;        // Sticky events
		logic [3:0]  mask;          // Interrupt mask
		logic [7:0]  pwm;           // Pin levels
		logic [7:0]  oe;            // Pin enables
		logic        flag;          // Event flag
		logic        irq;           // Interrupt level
		logic        cfg_loaded;    // Config bits taken after reset
	} pmc_state_t;
	pmc_state_t st;
	pmc_state_t next_st;

	// Duty store wiring
	logic        store_wr;
	logic [1:0]  store_wsel;
	logic [9:0]  store_wdata;
	logic [1:0]  store_rsel;
	logic [9:0]  store_rdata;
	logic [39:0] store_words;

	// Word index of a byte address
	function automatic logic [7:0] reg_index(input logic [11:0] a);
		return a[9:2];
	endfunction

	// Compare output of one channel against its duty
	function automatic logic cmp(input logic [11:0] c, input logic [9:0] d);
		return c < {2'b00, d};
	endfunction

	// Store slot for a duty index, or none
	function automatic logic [2:0] duty_slot(input logic [7:0] i);
		unique case (i)
			pmc_pkg::IDX_DUTY0: return 3'b100;
			pmc_pkg::IDX_DUTY4: return 3'b110;
			pmc_pkg::IDX_DUTY6: return 3'b111;
			default:            return 3'b000;
		endcase
	endfunction

	pmc_duty_store u_store (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.wr_en     (store_wr),
		.wr_sel    (store_wsel),
		.wr_data   (store_wdata),
		.rd_sel    (store_rsel),
		.rd_data   (store_rdata),
		.all_words (store_words)
	);

	// Next state: bus slave, counter, pins, events
	always_comb begin
		logic [7:0]  widx;
		logic [7:0]  ridx;
		logic [7:0]  wbyte;
		logic        wdo;
		logic [11:0] period;
		logic [9:0]  duty2;
		logic [9:0]  d0;
		logic [9:0]  d4;
		logic [9:0]  d6;
		logic [3:0]  ev;
		logic [7:0]  lvl;
		logic [2:0]  slot;
		next_st     = st;
		widx        = reg_index(st.waddr);
		ridx        = reg_index(s_axi_araddr);
		wbyte       = st.wstrb[0] ? st.wdata[7:0] : pmc_pkg::BYTE_ZERO;
		wdo         = 1'b0;
		ev          = 4'h0;
		lvl         = 8'h00;
		store_wr    = 1'b0;
		store_wsel  = 2'b00;
		store_wdata = pmc_pkg::DUTY_ZERO;
		store_rsel  = 2'b00;
		slot        = 3'b000;
		d0          = store_words[9:0];
		d4          = store_words[29:20];
		d6          = store_words[39:30];
		duty2       = {st.duty2_high[1:0], st.duty2_low};
		period      = {st.per_high[3:0], st.per_low};
		// Write channel: take address and data in either order
		next_st.awready = 1'b0;
		next_st.wready  = 1'b0;
		if (s_axi_awvalid && st.awready) begin
			next_st.got_aw = 1'b1;
			next_st.waddr  = s_axi_awaddr;
		end else if (!st.got_aw && !st.awready && s_axi_awvalid) begin
			next_st.awready = 1'b1;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.got_w = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end else if (!st.got_w && !st.wready && s_axi_wvalid) begin
			next_st.wready = 1'b1;
		end
		if (st.got_aw && st.got_w && !st.bvalid) begin
			wdo            = 1'b1;
			next_st.got_aw = 1'b0;
			next_st.got_w  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = pmc_pkg::RESP_OKAY;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Register writes; reserved bits are dropped
		if (wdo && st.wstrb[0]) begin
			slot = duty_slot(widx);
			unique case (widx)
				pmc_pkg::IDX_MODE_CTRL3:  next_st.ctrl3      = wbyte & pmc_pkg::MASK_CTRL3;
				pmc_pkg::IDX_DUTY2_HIGH:  next_st.duty2_high = wbyte & pmc_pkg::MASK_DUTY_HIGH;
				pmc_pkg::IDX_DUTY2_LOW:   next_st.duty2_low  = wbyte;
				pmc_pkg::IDX_PERIOD_LOW:  next_st.per_low    = wbyte;
				pmc_pkg::IDX_PERIOD_HIGH: next_st.per_high   = wbyte & pmc_pkg::MASK_PER_HIGH;
				pmc_pkg::IDX_IRQ_MASK:    next_st.mask       = wbyte[3:0] & pmc_pkg::MASK_EVENTS;
				pmc_pkg::IDX_DUTY0, pmc_pkg::IDX_DUTY4, pmc_pkg::IDX_DUTY6: begin
					store_wr    = 1'b1;
					store_wsel  = slot[1:0];
					store_wdata = st.wdata[9:0];
				end
				default: next_st.bresp = (widx == pmc_pkg::IDX_IRQ_STATUS || widx == pmc_pkg::IDX_PIN_STATUS)
					? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
			endcase
		end else if (wdo && !st.wstrb[0]) begin
			next_st.bresp = pmc_pkg::RESP_OKAY;
		end
		// Read channel: one cycle, duty words two
		next_st.arready = 1'b0;
		if (st.rd_store) begin
			next_st.rd_store = 1'b0;
			next_st.rvalid   = 1'b1;
			next_st.rdata    = {22'h00_0000, store_rdata};
		end else if (s_axi_arvalid && !st.arready && !st.rvalid) begin
			next_st.arready = 1'b1;
			next_st.rresp   = pmc_pkg::RESP_OKAY;
			slot            = duty_slot(ridx);
			store_rsel      = slot[1:0];
			if (slot[2]) begin
				next_st.rd_store = 1'b1;
			end else begin
				next_st.rvalid = 1'b1;
				unique case (ridx)
					pmc_pkg::IDX_MODE_CTRL3:  next_st.rdata = {24'h00_0000, st.ctrl3};
					pmc_pkg::IDX_DUTY2_HIGH:  next_st.rdata = {24'h00_0000, st.duty2_high};
					pmc_pkg::IDX_DUTY2_LOW:   next_st.rdata = {24'h00_0000, st.duty2_low};
					pmc_pkg::IDX_PERIOD_LOW:  next_st.rdata = {24'h00_0000, st.per_low};
					pmc_pkg::IDX_PERIOD_HIGH: next_st.rdata = {24'h00_0000, st.per_high};
					pmc_pkg::IDX_IRQ_STATUS:  next_st.rdata = {28'h000_0000, st.status};
					pmc_pkg::IDX_IRQ_MASK:    next_st.rdata = {28'h000_0000, st.mask};
					pmc_pkg::IDX_PIN_STATUS:  next_st.rdata = {16'h0000, st.oe, st.pwm};
					default: begin
						next_st.rdata = 32'h0000_0000;
						next_st.rresp = pmc_pkg::RESP_SLVERR;
					end
				endcase
			end
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// Counter: edge-aligned counts up and wraps, centre counts up and down
		if (!st.ctrl3[pmc_pkg::BIT_ALIGN]) begin
			next_st.dir = pmc_pkg::PMC_UP;
			if (st.cnt >= period) begin
				next_st.cnt = pmc_pkg::CNT_ZERO;
				ev[pmc_pkg::EV_UNDERFLOW] = 1'b1;
			end else begin
				next_st.cnt = st.cnt + pmc_pkg::CNT_ONE;
			end
		end else if (st.dir == pmc_pkg::PMC_UP) begin
			if (st.cnt >= period) begin
				next_st.dir = pmc_pkg::PMC_DOWN;
				ev[pmc_pkg::EV_OVERFLOW] = 1'b1;
			end else begin
				next_st.cnt = st.cnt + pmc_pkg::CNT_ONE;
			end
		end else begin
			if (st.cnt == pmc_pkg::CNT_ZERO) begin
				next_st.dir = pmc_pkg::PMC_UP;
				ev[pmc_pkg::EV_UNDERFLOW] = 1'b1;
			end else begin
				next_st.cnt = st.cnt - pmc_pkg::CNT_ONE;
			end
		end
		// Flag event choice only in centre mode; edge mode flags on wrap
		if (st.ctrl3[pmc_pkg::BIT_ALIGN]) begin
			next_st.flag = st.ctrl3[pmc_pkg::BIT_FLAG_SEL] ? ev[pmc_pkg::EV_OVERFLOW]
				: ev[pmc_pkg::EV_UNDERFLOW];
		end else begin
			next_st.flag = ev[pmc_pkg::EV_UNDERFLOW];
		end
		// Sticky status: set wins over write-one-to-clear
		if (wdo && st.wstrb[0] && widx == pmc_pkg::IDX_IRQ_STATUS) begin
			next_st.status = st.status & ~wbyte[3:0];
		end
		next_st.status = (next_st.status | ev) & pmc_pkg::MASK_EVENTS;
		next_st.irq    = |(next_st.status & next_st.mask);
		// Channel levels; grouped channels copy channel zero
		lvl[0] = cmp(st.cnt, d0);
		lvl[2] = st.ctrl3[pmc_pkg::BIT_GROUP] ? lvl[0] : cmp(st.cnt, duty2);
		lvl[4] = st.ctrl3[pmc_pkg::BIT_GROUP] ? lvl[0] : cmp(st.cnt, d4);
		lvl[6] = st.ctrl3[pmc_pkg::BIT_CH6_SRC] ? cmp(st.cnt, duty2) : cmp(st.cnt, d6);
		lvl[1] = ~lvl[0];
		lvl[3] = ~lvl[2];
		lvl[5] = ~lvl[4];
		lvl[7] = ~lvl[6];
		next_st.pwm = lvl;
		// Pin drive: Hi-Z bits override per-port modes
		for (int i = 0; i < 8; i++) begin
			if (i % 2 == 0) begin
				next_st.oe[i] = !st.ctrl3[pmc_pkg::BIT_EVEN_HIZ] && port_output_mode_regs[i / 2];
			end else begin
				next_st.oe[i] = !st.ctrl3[pmc_pkg::BIT_ODD_HIZ] && port_output_mode_regs[i / 2];
			end
		end
		next_st.oe[6] = next_st.oe[6] && channel6_pin_enable;
		// Config bits loaded at the first edge after reset release
		if (!st.cfg_loaded) begin
			next_st.cfg_loaded                  = 1'b1;
			next_st.ctrl3[pmc_pkg::BIT_EVEN_HIZ] = cfg_even_hiz;
			next_st.ctrl3[pmc_pkg::BIT_ODD_HIZ]  = cfg_odd_hiz;
			next_st.oe                          = 8'h00;
		end
		if (!aresetn) begin
			next_st = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	assign s_axi_awready  = st.awready;
	assign s_axi_wready   = st.wready;
	assign s_axi_bresp    = st.bresp;
	assign s_axi_bvalid   = st.bvalid;
	assign s_axi_arready  = st.arready;
	assign s_axi_rdata    = st.rdata;
	assign s_axi_rresp    = st.rresp;
	assign s_axi_rvalid   = st.rvalid;
	assign pwm_out        = st.pwm;
	assign pwm_oe         = st.oe;
	assign pwm_event_flag = st.flag;
	assign irq            = st.irq;
endmodule

// ==== testbench/pmc_checker.sv ====
// Purpose: Port-level assertions for the PWM output mode control block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the top module and sees its ports only
module pmc_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        cfg_even_hiz,
	input wire logic        cfg_odd_hiz,
	input wire logic [3:0]  port_output_mode_regs,
	input wire logic [7:0]  pwm_oe
);
	// One domain, so clock and reset are stated once for all properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Data beat taken; the response follows both beats
	sequence s_w_taken;
		s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// First edge after release, where the Hi-Z bits load from config
	sequence s_rel;
		$rose(aresetn);
	endsequence
	property p_write_answer;
		s_w_taken |-> ##[1:4] s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_read_answer;
		s_ar_taken |-> ##[0:1] s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_aw_cause;
		$rose(s_axi_awready) |-> $past(s_axi_awvalid);
	endproperty
	a_aw_cause: assert property (p_aw_cause) else $error("awready without request");
	property p_ar_cause;
		$rose(s_axi_arready) |-> $past(s_axi_arvalid);
	endproperty
	a_ar_cause: assert property (p_ar_cause) else $error("arready without request");
	// Registers other than the sixteen-bit pin status are at most ten bits, the rest reads zero
	property p_rdata_upper;
		s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h00_0000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	property p_even_hiz_rst;
		s_rel ##0 cfg_even_hiz |-> ##2 ((pwm_oe & 8'h55) == 8'h00) [*2];
	endproperty
	a_even_hiz_rst: assert property (p_even_hiz_rst) else $error("even pin driven after reset");
	property p_odd_hiz_rst;
		s_rel ##0 cfg_odd_hiz |-> ##2 ((pwm_oe & 8'haa) == 8'h00) [*2];
	endproperty
	a_odd_hiz_rst: assert property (p_odd_hiz_rst) else $error("odd pin driven after reset");
	// Two stable samples, since the enables are registered
	property p_mode_off;
		(port_output_mode_regs == 4'h0) [*2] |-> pwm_oe == 8'h00;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("pin driven with mode off");
endmodule
bind pmc_top pmc_checker u_pmc_checker (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .cfg_even_hiz, .cfg_odd_hiz,
	.port_output_mode_regs, .pwm_oe
);

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the PWM output mode control block
// Assumes: Bench drives every port itself, registers over AXI4-Lite
// Notes:   A period of four keeps pulse counts short
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Short aliases for the busiest register indexes
	localparam logic [7:0] CTL = pmc_pkg::IDX_MODE_CTRL3;
	localparam logic [7:0] STA = pmc_pkg::IDX_IRQ_STATUS;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        cfg_even_hiz, cfg_odd_hiz, channel6_pin_enable, pwm_event_flag, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb, port_output_mode_regs;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  pwm_out, pwm_oe;
	int          error_cnt, check_count, hits;
	// Readback table: written all ones, reserved positions come back zero
	logic [7:0]  ridx [3] = '{CTL, pmc_pkg::IDX_DUTY2_HIGH, pmc_pkg::IDX_PERIOD_HIGH};
	logic [31:0] rexp [3] = '{32'h0000_00f3, 32'h0000_0003, 32'h0000_000f};
	pmc_top dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cfg_even_hiz, .cfg_odd_hiz, .port_output_mode_regs, .channel6_pin_enable, .pwm_out, .pwm_oe,
		.pwm_event_flag, .irq
	);
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Verdict, reached from the main flow and from any timeout
	task automatic report_and_stop();
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// A wait that ran out counts as a mismatch and ends the run
	task automatic timeout();
		error_cnt++;
		report_and_stop();
	endtask
	// Config bits are held steady across the release edge
	task automatic do_reset(input logic ev, input logic od);
		cfg_even_hiz <= ev;
		cfg_odd_hiz  <= od;
		aresetn      <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st = 4'hf);
		int n;
		@(posedge aclk);
		s_axi_awaddr  <= {2'b00, idx, 2'b00};
		s_axi_wdata   <= d;
		s_axi_wstrb   <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 40)
			timeout();
	endtask
	task automatic rd(input logic [7:0] idx);
		int n;
		@(posedge aclk);
		s_axi_araddr  <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		rv  = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 40)
			timeout();
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string name);
		rd(idx);
		chk(name, rv, exp);
	endtask
	// Count cycles where two pins disagree, after the new setting lands
	task automatic pin_diff(input int a, input int b);
		repeat (3) @(posedge aclk);
		hits = 0;
		repeat (20) begin
			@(posedge aclk);
			if (pwm_out[a] !== pwm_out[b])
				hits++;
		end
	endtask
	task automatic flag_count();
		repeat (3) @(posedge aclk);
		hits = 0;
		repeat (40) begin
			@(posedge aclk);
			if (pwm_event_flag === 1'b1)
				hits++;
		end
	endtask
	// Settle first so a pulse of the old setting is not taken
	task automatic wait_flag(input int bound);
		int n;
		repeat (3) @(posedge aclk);
		for (n = 0; n < bound; n++) begin
			@(posedge aclk);
			if (pwm_event_flag === 1'b1)
				break;
		end
		if (n == bound)
			timeout();
	endtask
	initial begin
		error_cnt = 0;
		check_count = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		port_output_mode_regs = 4'hf;
		channel6_pin_enable = 1'b1;
		do_reset(1'b1, 1'b0);
		rd_chk(CTL, 32'h0000_0080, "ctrl_reset_even");
		chk("oe_even_hiz", 32'(pwm_oe), 32'h0000_00aa);
		do_reset(1'b0, 1'b1);
		rd_chk(CTL, 32'h0000_0040, "ctrl_reset_odd");
		chk("oe_odd_hiz", 32'(pwm_oe), 32'h0000_0055);
		channel6_pin_enable <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("oe_pin6_off", 32'(pwm_oe), 32'h0000_0015);
		channel6_pin_enable <= 1'b1;
		wr(CTL, 32'h0000_0000);
		port_output_mode_regs <= 4'h5;
		repeat (3) @(posedge aclk);
		chk("oe_mode_pairs", 32'(pwm_oe), 32'h0000_0033);
		port_output_mode_regs <= 4'h0;
		repeat (3) @(posedge aclk);
		chk("oe_mode_off", 32'(pwm_oe), 32'h0000_0000);
		port_output_mode_regs <= 4'hf;
		for (int i = 0; i < 3; i++) begin
			wr(ridx[i], 32'hffff_ffff);
			rd_chk(ridx[i], rexp[i], "reg_readback");
		end
		// No byte strobe: the write is dropped
		wr(CTL, 32'h0000_0000, 4'h0);
		rd_chk(CTL, 32'h0000_00f3, "ctrl_no_strobe");
		wr(8'h10, 32'h0000_0001);
		chk("unmapped_write", 32'(rsp), 32'(pmc_pkg::RESP_SLVERR));
		rd(8'h10);
		chk("unmapped_read", 32'(rsp), 32'(pmc_pkg::RESP_SLVERR));
		// Reset again so the long period written above is gone
		do_reset(1'b0, 1'b0);
		rd_chk(CTL, 32'h0000_0000, "ctrl_reset_clear");
		wr(pmc_pkg::IDX_PERIOD_LOW, 32'h0000_0004);
		wr(pmc_pkg::IDX_DUTY0, 32'h0000_0002);
		wr(pmc_pkg::IDX_DUTY2_LOW, 32'h0000_0003);
		wr(pmc_pkg::IDX_DUTY4, 32'h0000_0001);
		wr(CTL, 32'h0000_0020);
		pin_diff(0, 2);
		chk("group_pin2", hits, 0);
		pin_diff(0, 4);
		chk("group_pin4", hits, 0);
		wr(CTL, 32'h0000_0000);
		pin_diff(0, 2);
		chk("split_pin2", 32'(hits != 0), 32'h0000_0001);
		wr(CTL, 32'h0000_0002);
		pin_diff(6, 2);
		chk("pin6_from_two", hits, 0);
		wr(CTL, 32'h0000_0000);
		pin_diff(6, 2);
		chk("pin6_own", 32'(hits != 0), 32'h0000_0001);
		// Edge mode wraps every five cycles whatever the select bit says
		for (int s = 0; s < 2; s++) begin
			wr(CTL, 32'(s));
			flag_count();
			chk("edge_flags", hits, 8);
		end
		wr(CTL, 32'h0000_0010);
		flag_count();
		chk("centre_flags", hits, 4);
		// Underflow falls in the high part of channel zero, overflow in the low
		for (int s = 0; s < 2; s++) begin
			wr(CTL, 32'h0000_0010 | 32'(s));
			wait_flag(100);
			chk("flag_level", 32'(pwm_out[0]), 32'(1 - s));
		end
		wr(pmc_pkg::IDX_IRQ_MASK, 32'h0000_0000);
		wr(CTL, 32'h0000_0010);
		wr(pmc_pkg::IDX_PERIOD_LOW, 32'h0000_00ff);
		// Clear old events so the underflow seen below is a fresh one
		wr(STA, 32'h0000_0003);
		wait_flag(1200);
		rd(STA);
		chk("status_underflow", 32'(rv[0]), 32'h0000_0001);
		chk("irq_masked", 32'(irq), 32'h0000_0000);
		wr(pmc_pkg::IDX_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk("irq_raised", 32'(irq), 32'h0000_0001);
		wr(STA, 32'h0000_0003);
		repeat (2) @(posedge aclk);
		chk("irq_cleared", 32'(irq), 32'h0000_0000);
		rd_chk(STA, 32'h0000_0000, "status_cleared");
		report_and_stop();
	end
endmodule
